// file: design/pfl_map.svh
/*
 * Constants of the parallel fuse, lock and signature access path.
 * Assumes a 40 MHz system clock on both ends of the programming port.
 */
`ifndef PFL_MAP_SVH
`define PFL_MAP_SVH

// ============================================================
// Commands loaded through the programming port.
`define PFL_CMD_CHIP_ERASE 8'h80
`define PFL_CMD_WR_FUSE    8'h40
`define PFL_CMD_WR_LOCK    8'h20
`define PFL_CMD_RD_FUSE    8'h04
`define PFL_CMD_RD_SIG     8'h08

// ============================================================
// Load selector codes and field positions.
`define PFL_SEL_ADDR       2'h0
`define PFL_SEL_DATA       2'h1
`define PFL_SEL_CMD        2'h2
`define PFL_LOCK_HI        2
`define PFL_LOCK_LO        1
`define PFL_SIG_LAST       8'h02

// ============================================================
// Power-up values of the nonvolatile cells, blank means unprogrammed.
`define PFL_FUSE_BLANK     6'h3f
`define PFL_LOCK_BLANK     2'h3

// ============================================================
// Timing, in nanoseconds as specified; the guard time is in clock cycles.
`define PFL_CLK_NS         25
`define PFL_SETUP_NS       67
`define PFL_BUSY_NS        700000
`define PFL_WR_CE_NS       10000000
`define PFL_WR_PFB_NS      1500000
`define PFL_WR_NS          67
`define PFL_OE_DV_NS       20
`define PFL_GUARD_CYC      8

`endif

// file: design/pfl_pkg.sv
/*
 * Types and shared arithmetic of the programming port.
 * Assumes pfl_map.svh is included by every user of the constants.
 */
package pfl_pkg;

   // Operations that the programmer end can run.
   typedef enum logic [2:0] {
      PFL_OP_ERASE,
      PFL_OP_WR_FUSE,
      PFL_OP_WR_LOCK,
      PFL_OP_RD_FUSE,
      PFL_OP_RD_LOCK,
      PFL_OP_RD_SIG
   } pfl_op_e;

   // Least time in whole clock cycles, never less than one.
   function automatic int unsigned pfl_min_cyc(input int unsigned ns,
                                               input int unsigned per);
      int unsigned c;
      c = (ns + per - 1) / per;
      return (c == 0) ? 1 : c;
   endfunction

endpackage

// file: design/pfl_if.sv
/*
 * Pins of the parallel programming port between programmer and device.
 * Assumes the shared data bus floats high when nobody drives it.
 */
`timescale 1ns/10ps
interface pfl_if;
   logic       prog_clk;       // programming_clock_pin level.
   logic [1:0] load_sel;
   logic       byte_select;
   logic       oe_n;
   logic       wr_n;
   logic       ready_busy_flag;
   logic [7:0] prog_data_o;
   logic       prog_data_oe;
   logic [7:0] dev_data_o;
   logic       dev_data_oe;
   logic [7:0] data_bus;

   // Resolved bus level; an undriven bus reads as all ones.
   assign data_bus = dev_data_oe ? dev_data_o
                   : (prog_data_oe ? prog_data_o : 8'hff);

   modport dev  (input prog_clk, load_sel, byte_select, oe_n, wr_n,
                 data_bus, output ready_busy_flag, dev_data_o, dev_data_oe);
   modport prog (input ready_busy_flag, data_bus, output prog_clk,
                 load_sel, byte_select, oe_n, wr_n, prog_data_o,
                 prog_data_oe);
endinterface

// file: design/pfl_dev.sv
/*
 * Device end of the parallel programming port: fuse and lock storage,
 * readback and identification bytes, and the ready/busy flag.
 * Assumes the pins come from another clock domain and are synchronised.
 */
`timescale 1ns/10ps
`include "pfl_map.svh"
module pfl_dev
   import pfl_pkg::*;
#(
   parameter int unsigned BUSY_CYC = `PFL_BUSY_NS / `PFL_CLK_NS,
   parameter logic [7:0]  SIG_0    = 8'h11,   // Arbitrary value.
   parameter logic [7:0]  SIG_1    = 8'h22,   // Arbitrary value.
   parameter logic [7:0]  SIG_2    = 8'h33    // Arbitrary value.
)(
   input  wire logic       clk,
   input  wire logic       reset,
   pfl_if.dev              pins,
   output      logic [5:0] fuse_state,
   output      logic [1:0] lock_state
);

   // ============================================================
   // Pin synchronisers.
   // Two flops on every pin; only the second stage is read further on.
   logic [13:0] meta_q;
   logic [13:0] sync_q;
   logic [13:0] pin_raw;

   assign pin_raw = {pins.prog_clk, pins.load_sel, pins.byte_select,
                     pins.oe_n, pins.wr_n, pins.data_bus};

   // Plain two-stage register chain, no logic in between.
   always_ff @(posedge clk) begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
   end

   logic       pclk_s;
   logic [1:0] sel_s;
   logic       bs_s;
   logic       oe_n_s;
   logic       wr_n_s;
   logic [7:0] data_s;

   assign pclk_s = sync_q[13];
   assign sel_s  = sync_q[12:11];
   assign bs_s   = sync_q[10];
   assign oe_n_s = sync_q[9];
   assign wr_n_s = sync_q[8];
   assign data_s = sync_q[7:0];

   // ============================================================
   // Nonvolatile cells.
   // Held without reset so that a reset of the logic never alters them;
   // the power-up value stands for a blank part.
   logic [5:0] fuse_q = `PFL_FUSE_BLANK;
   logic [1:0] lock_q = `PFL_LOCK_BLANK;
   logic [5:0] fuse_d;
   logic [1:0] lock_d;

   // ============================================================
   // Control and readback state.
   localparam int unsigned CW = $clog2(BUSY_CYC + 1);
   logic [7:0]    cmd_q,     cmd_d;
   logic [7:0]    addr_q,    addr_d;
   logic [7:0]    wdata_q,   wdata_d;
   logic          pclk_p_q,  pclk_p_d;
   logic          wr_p_q,    wr_p_d;
   logic          run_q,     run_d;
   logic [CW-1:0] cnt_q,     cnt_d;
   logic          rdy_q,     rdy_d;
   logic [7:0]    dout_q,    dout_d;
   logic          doe_q,     doe_d;
   logic          pclk_rise;
   logic          wr_fall;
   logic          wr_rise;

   // Edge detectors look only at synchronised levels.
   assign pclk_rise = pclk_s & ~pclk_p_q;
   assign wr_fall   = ~wr_n_s & wr_p_q;
   assign wr_rise   = wr_n_s & ~wr_p_q;

   // Selected identification byte, ones outside the defined range.
   function automatic logic [7:0] sig_byte(input logic [7:0] a);
      case (a)
         8'h00:   sig_byte = SIG_0;
         8'h01:   sig_byte = SIG_1;
         `PFL_SIG_LAST: sig_byte = SIG_2;
         default: sig_byte = 8'hff;
      endcase
   endfunction

   // Next-state logic of loading, programming, busy timing and readback.
   always_comb begin
      cmd_d    = cmd_q;
      addr_d   = addr_q;
      wdata_d  = wdata_q;
      pclk_p_d = pclk_s;
      wr_p_d   = wr_n_s;
      run_d    = run_q;
      cnt_d    = cnt_q;
      rdy_d    = rdy_q;
      fuse_d   = fuse_q;
      lock_d   = lock_q;
      dout_d   = dout_q;
      doe_d    = 1'b0;

      // Command, address and data are captured on the clock pin rise.
      if (pclk_rise) begin
         case (sel_s)
            `PFL_SEL_CMD:  cmd_d   = data_s;
            `PFL_SEL_ADDR: addr_d  = data_s;
            `PFL_SEL_DATA: wdata_d = data_s;
            default:       ;
         endcase
      end

      // The write strobe fall starts the operation of the loaded command.
      if (wr_fall) begin
         case (cmd_q)
            `PFL_CMD_CHIP_ERASE: begin
               lock_d = `PFL_LOCK_BLANK;
               run_d  = 1'b1;
               cnt_d  = '0;
            end
            `PFL_CMD_WR_LOCK: begin
               // A one never unprograms, so only erase can set a cleared bit again.
               lock_d = lock_q & wdata_q[`PFL_LOCK_HI:`PFL_LOCK_LO];
               run_d  = 1'b1;
               cnt_d  = '0;
            end
            `PFL_CMD_WR_FUSE: begin
               fuse_d = wdata_q[5:0];
            end
            default: ;
         endcase
      end

      // Self-timed operation: the flag drops on the strobe rise only if
      // the timer still runs, so a long strobe shows no pulse at all.
      if (run_q) begin
         if (cnt_q == CW'(BUSY_CYC - 1)) begin
            run_d = 1'b0;
            rdy_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CW'(1);
            if (wr_rise) begin
               rdy_d = 1'b0;
            end
         end
      end

      // Readback drives only while output enable is low.
      if (!oe_n_s) begin
         case (cmd_q)
            `PFL_CMD_RD_FUSE: begin
               doe_d = 1'b1;
               if (bs_s) begin
                  dout_d = {5'h1f, lock_q, 1'b1};
               end else begin
                  dout_d = {2'h3, fuse_q};
               end
            end
            `PFL_CMD_RD_SIG: begin
               doe_d  = 1'b1;
               dout_d = sig_byte(addr_q);
            end
            default: ;
         endcase
      end
   end

   // Registers of the control path; cells keep their value over reset.
   always_ff @(posedge clk) begin
      // Cells are frozen while reset is high, so a strobe caught in
      // reset can never alter them.
      if (!reset) begin
         fuse_q <= fuse_d;
         lock_q <= lock_d;
      end
      if (reset) begin
         cmd_q    <= 8'h00;
         addr_q   <= 8'h00;
         wdata_q  <= 8'hff;
         pclk_p_q <= 1'b0;
         wr_p_q   <= 1'b1;
         run_q    <= 1'b0;
         cnt_q    <= '0;
         rdy_q    <= 1'b1;
         dout_q   <= 8'h00;
         doe_q    <= 1'b0;
      end else begin
         cmd_q    <= cmd_d;
         addr_q   <= addr_d;
         wdata_q  <= wdata_d;
         pclk_p_q <= pclk_p_d;
         wr_p_q   <= wr_p_d;
         run_q    <= run_d;
         cnt_q    <= cnt_d;
         rdy_q    <= rdy_d;
         dout_q   <= dout_d;
         doe_q    <= doe_d;
      end
   end

   // ============================================================
   // Outputs, all straight from flops.
   assign pins.ready_busy_flag = rdy_q;
   assign pins.dev_data_o      = dout_q;
   assign pins.dev_data_oe     = doe_q;
   assign fuse_state           = fuse_q;
   assign lock_state           = lock_q;

endmodule

// file: design/pfl_prog.sv
/*
 * Programmer end of the parallel programming port: runs one erase,
 * fuse write, lock write or readback per start pulse.
 * Assumes the user holds op, wdata and addr stable while busy is high.
 */
`timescale 1ns/10ps
`include "pfl_map.svh"
module pfl_prog
   import pfl_pkg::*;
#(
   parameter int unsigned CE_CYC  = `PFL_WR_CE_NS / `PFL_CLK_NS,
   parameter int unsigned PFB_CYC = `PFL_WR_PFB_NS / `PFL_CLK_NS
)(
   input  wire logic       clk,
   input  wire logic       reset,
   pfl_if.prog             pins,
   input  wire logic       start,
   input  wire pfl_op_e    op,
   input  wire logic [7:0] wdata,
   input  wire logic [7:0] addr,
   output      logic       busy,
   output      logic       done,
   output      logic [7:0] rdata
);

   localparam int unsigned SU_CYC = pfl_min_cyc(`PFL_SETUP_NS, `PFL_CLK_NS);
   localparam int unsigned WR_CYC = pfl_min_cyc(`PFL_WR_NS, `PFL_CLK_NS);
   localparam int unsigned RD_CYC =
      pfl_min_cyc(`PFL_OE_DV_NS, `PFL_CLK_NS) + `PFL_GUARD_CYC;

   typedef enum logic [3:0] {
      PFL_IDLE, PFL_SETUP, PFL_CLKHI, PFL_HOLD, PFL_WRLO, PFL_WAITRDY,
      PFL_RDWAIT, PFL_RDEND, PFL_DONE
   } pfl_st_e;

   // ============================================================
   // Ready flag synchroniser and captured data.
   logic       rdy_m_q;
   logic       rdy_s_q;
   logic [7:0] bus_m_q;
   logic [7:0] bus_s_q;

   // Two flops before any logic reads these pins.
   always_ff @(posedge clk) begin
      rdy_m_q <= pins.ready_busy_flag;
      rdy_s_q <= rdy_m_q;
      bus_m_q <= pins.data_bus;
      bus_s_q <= bus_m_q;
   end

   // ============================================================
   // Sequencer.
   pfl_st_e     st_q,    st_d;
   logic [23:0] tmr_q,   tmr_d;
   logic        second_q, second_d;
   logic        pclk_q,  pclk_d;
   logic [1:0]  sel_q,   sel_d;
   logic        bs_q,    bs_d;
   logic        oe_n_q,  oe_n_d;
   logic        wr_n_q,  wr_n_d;
   logic [7:0]  pdo_q,   pdo_d;
   logic        pdoe_q,  pdoe_d;
   logic        busy_q,  busy_d;
   logic        done_q,  done_d;
   logic [7:0]  rdata_q, rdata_d;
   logic        is_wr;

   assign is_wr = (op == PFL_OP_ERASE) || (op == PFL_OP_WR_FUSE)
               || (op == PFL_OP_WR_LOCK);

   // Strobe width per operation; the lock write uses the plain minimum.
   function automatic logic [23:0] wr_width(input pfl_op_e o);
      case (o)
         PFL_OP_ERASE:   wr_width = 24'(CE_CYC);
         PFL_OP_WR_FUSE: wr_width = 24'(PFB_CYC);
         default:        wr_width = 24'(WR_CYC);
      endcase
   endfunction

   // Next state: load command, then one address or data load except for
   // erase and the fuse or lock read, then either the strobe or the
   // output-enable read.
   always_comb begin
      st_d     = st_q;
      tmr_d    = (tmr_q == 24'h0) ? 24'h0 : tmr_q - 24'h1;
      second_d = second_q;
      pclk_d   = pclk_q;
      sel_d    = sel_q;
      bs_d     = bs_q;
      oe_n_d   = oe_n_q;
      wr_n_d   = wr_n_q;
      pdo_d    = pdo_q;
      pdoe_d   = pdoe_q;
      busy_d   = busy_q;
      done_d   = 1'b0;
      rdata_d  = rdata_q;
      case (st_q)
         PFL_IDLE: begin
            if (start) begin
               busy_d   = 1'b1;
               pdoe_d   = 1'b1;
               sel_d    = `PFL_SEL_CMD;
               second_d = (op != PFL_OP_ERASE) && (op != PFL_OP_RD_FUSE)
                       && (op != PFL_OP_RD_LOCK);
               case (op)
                  PFL_OP_ERASE:   pdo_d = `PFL_CMD_CHIP_ERASE;
                  PFL_OP_WR_FUSE: pdo_d = `PFL_CMD_WR_FUSE;
                  PFL_OP_WR_LOCK: pdo_d = `PFL_CMD_WR_LOCK;
                  PFL_OP_RD_SIG:  pdo_d = `PFL_CMD_RD_SIG;
                  default:        pdo_d = `PFL_CMD_RD_FUSE;
               endcase
               tmr_d = 24'(SU_CYC);
               st_d  = PFL_SETUP;
            end
         end
         PFL_SETUP: if (tmr_q == 24'h0) begin
            pclk_d = 1'b1;
            tmr_d  = 24'(SU_CYC);
            st_d   = PFL_CLKHI;
         end
         PFL_CLKHI: if (tmr_q == 24'h0) begin
            pclk_d = 1'b0;
            tmr_d  = 24'(SU_CYC);
            st_d   = PFL_HOLD;
         end
         PFL_HOLD: if (tmr_q == 24'h0) begin
            if (second_q) begin
               second_d = 1'b0;
               if (op == PFL_OP_RD_SIG) begin
                  sel_d = `PFL_SEL_ADDR;
                  pdo_d = addr;
               end else begin
                  sel_d = `PFL_SEL_DATA;
                  pdo_d = wdata;
               end
               tmr_d = 24'(SU_CYC);
               st_d  = PFL_SETUP;
            end else if (is_wr) begin
               wr_n_d = 1'b0;
               tmr_d  = wr_width(op);
               st_d   = PFL_WRLO;
            end else begin
               pdoe_d = 1'b0;
               bs_d   = (op == PFL_OP_RD_LOCK);
               tmr_d  = 24'(SU_CYC);
               st_d   = PFL_RDWAIT;
            end
         end
         PFL_WRLO: if (tmr_q == 24'h0) begin
            wr_n_d = 1'b1;
            tmr_d  = 24'(`PFL_GUARD_CYC);
            st_d   = (op == PFL_OP_WR_FUSE) ? PFL_DONE : PFL_WAITRDY;
         end
         PFL_WAITRDY: if (tmr_q == 24'h0 && rdy_s_q) begin
            st_d = PFL_DONE;
         end
         PFL_RDWAIT: begin
            oe_n_d = 1'b0;
            if (oe_n_q == 1'b1) begin
               tmr_d = 24'(RD_CYC);
            end else if (tmr_q == 24'h0) begin
               rdata_d = bus_s_q;
               oe_n_d  = 1'b1;
               tmr_d   = 24'(RD_CYC);
               st_d    = PFL_RDEND;
            end
         end
         PFL_RDEND: if (tmr_q == 24'h0) begin
            bs_d = 1'b0;
            st_d = PFL_DONE;
         end
         PFL_DONE: begin
            pdoe_d = 1'b0;
            busy_d = 1'b0;
            done_d = 1'b1;
            st_d   = PFL_IDLE;
         end
         default: st_d = PFL_IDLE;
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q     <= PFL_IDLE;
         tmr_q    <= 24'h0;
         second_q <= 1'b0;
         pclk_q   <= 1'b0;
         sel_q    <= `PFL_SEL_CMD;
         bs_q     <= 1'b0;
         oe_n_q   <= 1'b1;
         wr_n_q   <= 1'b1;
         pdo_q    <= 8'hff;
         pdoe_q   <= 1'b0;
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
         rdata_q  <= 8'h00;
      end else begin
         st_q     <= st_d;
         tmr_q    <= tmr_d;
         second_q <= second_d;
         pclk_q   <= pclk_d;
         sel_q    <= sel_d;
         bs_q     <= bs_d;
         oe_n_q   <= oe_n_d;
         wr_n_q   <= wr_n_d;
         pdo_q    <= pdo_d;
         pdoe_q   <= pdoe_d;
         busy_q   <= busy_d;
         done_q   <= done_d;
         rdata_q  <= rdata_d;
      end
   end

   // ============================================================
   // Outputs from flops.
   assign pins.prog_clk     = pclk_q;
   assign pins.load_sel     = sel_q;
   assign pins.byte_select  = bs_q;
   assign pins.oe_n         = oe_n_q;
   assign pins.wr_n         = wr_n_q;
   assign pins.prog_data_o  = pdo_q;
   assign pins.prog_data_oe = pdoe_q;
   assign busy              = busy_q;
   assign done              = done_q;
   assign rdata             = rdata_q;

endmodule

// file: test/pfl_properties.sv
/*
 * Checker of the programming port between the programmer and device ends.
 * Assumes the testbench feeds it the pins of the shared interface.
 */
`timescale 1ns/10ps
`include "pfl_map.svh"
module pfl_properties #(
   parameter int BUSY_CYC = 50
)(
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       prog_clk,
   input wire logic [1:0] load_sel,
   input wire logic       byte_select,
   input wire logic       oe_n,
   input wire logic       wr_n,
   input wire logic       ready_busy_flag,
   input wire logic [7:0] dev_data_o,
   input wire logic       dev_data_oe,
   input wire logic [7:0] data_bus
);
   logic       pclk_q;
   logic       pclk_d;
   logic [7:0] cmd_q;
   logic [7:0] cmd_d;

   // ============================================================
   // Helper state
   // The last command is caught at the pin's rise, ahead of the device's
   // own synchroniser, so it is valid before the device acts on it.
   always_comb begin
      pclk_d = prog_clk;
      cmd_d  = cmd_q;
      if (prog_clk && !pclk_q && load_sel == `PFL_SEL_CMD) begin
         cmd_d = data_bus;
      end
   end

   // Registers of the helper state.
   always_ff @(posedge clk) begin
      if (reset) begin
         pclk_q <= 1'b0;
         cmd_q  <= 8'h00;
      end else begin
         pclk_q <= pclk_d;
         cmd_q  <= cmd_d;
      end
   end

   // ============================================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_RELEASE_AFTER_OE: assert property (
      $rose(oe_n) |-> ##[1:4] !dev_data_oe)
      else $error("device still drives after read drive ended");
   AST_NO_DRIVE_IDLE: assert property (
      oe_n [*4] |-> !dev_data_oe)
      else $error("device drives while read drive is high");
   AST_DRIVE_ON_READ: assert property (
      $fell(oe_n) && (cmd_q == `PFL_CMD_RD_FUSE || cmd_q == `PFL_CMD_RD_SIG)
      |-> ##[1:4] dev_data_oe)
      else $error("device did not drive readback");
   AST_LOCK_LAYOUT: assert property (
      dev_data_oe && cmd_q == `PFL_CMD_RD_FUSE && byte_select
      && $past(byte_select, 4) |-> dev_data_o[7:3] == 5'h1f && dev_data_o[0])
      else $error("lock readback reserved bits wrong");
   AST_FUSE_LAYOUT: assert property (
      dev_data_oe && cmd_q == `PFL_CMD_RD_FUSE && !byte_select
      && !$past(byte_select, 4) |-> dev_data_o[7:6] == 2'h3)
      else $error("fuse readback upper bits wrong");
   AST_BUSY_AFTER_LOCK: assert property (
      $rose(wr_n) && cmd_q == `PFL_CMD_WR_LOCK |-> ##[2:5] !ready_busy_flag)
      else $error("no busy pulse after lock write");
   AST_NO_PULSE_LONG: assert property (
      $rose(wr_n) && cmd_q == `PFL_CMD_CHIP_ERASE |-> ready_busy_flag [*6])
      else $error("busy pulse seen after long strobe");
   AST_FUSE_NO_BUSY: assert property (
      cmd_q == `PFL_CMD_WR_FUSE |-> ready_busy_flag)
      else $error("busy flag moved during fuse write");
   AST_BUSY_ENDS: assert property (
      $fell(ready_busy_flag) |-> ##[1:BUSY_CYC] ready_busy_flag)
      else $error("busy flag stayed low too long");
endmodule

// file: test/pfl_test.sv
/*
 * Self-checking testbench: programmer end joined to device end.
 * Assumes both ends reset synchronously and share one 40 MHz clock.
 */
`timescale 1ns/10ps
`include "pfl_map.svh"
module pfl_test
   import pfl_pkg::*;
;
   localparam int BUSY_CYC = 50;

   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       start = 1'b0;
   pfl_op_e    op = PFL_OP_RD_FUSE;
   logic [7:0] wdata = 8'hff;
   logic [7:0] addr = 8'h00;
   logic       busy;
   logic       done;
   logic [7:0] rdata;
   logic [5:0] fuse_state;
   logic [1:0] lock_state;
   int         fail_count = 0;
   int         tests_run = 0;
   int         low_cnt = 0;
   int         mark = 0;

   // ============================================================
   // Structure
   pfl_if pins_if ();
   pfl_dev #(.BUSY_CYC(BUSY_CYC), .SIG_0(8'h5a), .SIG_1(8'h3c),
      .SIG_2(8'h96)) i_pfl_dev (.clk(clk), .reset(reset),
      .pins(pins_if), .fuse_state(fuse_state), .lock_state(lock_state));
   pfl_prog #(.CE_CYC(100), .PFB_CYC(80)) i_pfl_prog (.clk(clk),
      .reset(reset), .pins(pins_if), .start(start), .op(op),
      .wdata(wdata), .addr(addr), .busy(busy), .done(done), .rdata(rdata));
   pfl_properties #(.BUSY_CYC(BUSY_CYC)) i_pfl_properties (.clk(clk),
      .reset(reset), .prog_clk(pins_if.prog_clk),
      .load_sel(pins_if.load_sel), .byte_select(pins_if.byte_select),
      .oe_n(pins_if.oe_n), .wr_n(pins_if.wr_n),
      .ready_busy_flag(pins_if.ready_busy_flag),
      .dev_data_o(pins_if.dev_data_o), .dev_data_oe(pins_if.dev_data_oe),
      .data_bus(pins_if.data_bus));

   // Clock; the signature values above are arbitrary.
   always #12.5 clk = ~clk;

   // Busy cycles are counted so each operation can tell if a pulse showed.
   // Sampling on the falling edge keeps clear of the flag's own update.
   always @(negedge clk) begin
      if (pins_if.ready_busy_flag === 1'b0) low_cnt++;
   end

   // ============================================================
   // Tasks
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_pulse(input bit want);
      tests_run++;
      if ((low_cnt != mark) != want) begin
         fail_count++;
         $display("unexpected at %0t: busy pulse seen %0b", $time, !want);
      end
   endtask

   // One operation; the next start waits for the done pulse.
   task automatic run_op(input pfl_op_e o, input logic [7:0] d,
                         input logic [7:0] a);
      int n;
      n = 0;
      mark = low_cnt;
      start <= 1'b1;
      op    <= o;
      wdata <= d;
      addr  <= a;
      @(posedge clk);
      start <= 1'b0;
      // The done pulse is looked at mid-cycle, where it stands settled.
      while (done !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000) begin
         fail_count++;
         $display("unexpected at %0t: no done", $time);
         wrap_up();
      end
      @(posedge clk);
   endtask

   task automatic rd(input pfl_op_e o, input logic [7:0] a,
                     input logic [7:0] exp);
      run_op(o, 8'hff, a);
      chk8(rdata, exp);
   endtask

   task automatic do_reset(input int n);
      reset <= 1'b1;
      repeat (n) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
   endtask

   // ============================================================
   // Watchdog, far beyond the roughly one thousand cycles the tests need.
   initial begin
      #(25 * 40000);
      fail_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      wrap_up();
   end

   // ============================================================
   // Tests
   initial begin
      logic [7:0] sig_exp [4];
      sig_exp = '{8'h5a, 8'h3c, 8'h96, 8'hff};
      do_reset(10);
      rd(PFL_OP_RD_FUSE, 8'h00, 8'hff);
      rd(PFL_OP_RD_LOCK, 8'h00, 8'hff);
      $display("blank readback done");
      run_op(PFL_OP_WR_FUSE, 8'hc5, 8'h00);
      chk_pulse(1'b0);
      chk8({2'h0, fuse_state}, 8'h05);
      rd(PFL_OP_RD_FUSE, 8'h00, 8'hc5);
      $display("fuse write done");
      run_op(PFL_OP_WR_LOCK, 8'hfb, 8'h00);
      chk_pulse(1'b1);
      chk8({6'h00, lock_state}, 8'h01);
      rd(PFL_OP_RD_LOCK, 8'h00, 8'hfb);
      run_op(PFL_OP_WR_LOCK, 8'hff, 8'h00);
      rd(PFL_OP_RD_LOCK, 8'h00, 8'hfb);
      run_op(PFL_OP_WR_LOCK, 8'hfd, 8'h00);
      rd(PFL_OP_RD_LOCK, 8'h00, 8'hf9);
      $display("lock write done");
      do_reset(3);
      rd(PFL_OP_RD_FUSE, 8'h00, 8'hc5);
      rd(PFL_OP_RD_LOCK, 8'h00, 8'hf9);
      $display("reset retention done");
      run_op(PFL_OP_ERASE, 8'hff, 8'h00);
      chk_pulse(1'b0);
      chk8({6'h00, lock_state}, 8'h03);
      rd(PFL_OP_RD_LOCK, 8'h00, 8'hff);
      rd(PFL_OP_RD_FUSE, 8'h00, 8'hc5);
      $display("erase done");
      for (int i = 0; i < 4; i++) begin
         rd(PFL_OP_RD_SIG, 8'(i), sig_exp[i]);
      end
      $display("signature done");
      wrap_up();
   end
endmodule
